// ### include/spimsc_regs.svh
`ifndef SPIMSC_REGS_SVH
`define SPIMSC_REGS_SVH
// ****************************************
// Control word layout
// ****************************************
`define SPIMSC_CR_IRQ_EN      7
`define SPIMSC_CR_PORT_EN     6
`define SPIMSC_CR_DIV2        5
`define SPIMSC_CR_MASTER      4
`define SPIMSC_CR_CLOCK_POLARITY_BIT        3
`define SPIMSC_CR_CLOCK_PHASE_BIT        2
`define SPIMSC_CR_SPR_HI      1
`define SPIMSC_CR_SPR_LO      0
// ****************************************
// Reset values and counts
// ****************************************
`define SPIMSC_CR_RESET       8'h00
`define SPIMSC_BYTE_RESET     8'h00
`define SPIMSC_LAST_EDGE      4'hF
`define SPIMSC_LAST_BIT       3'h7
// ****************************************
// Half period of master clock, in REF_CLK cycles, minus one
// ****************************************
`define SPIMSC_HALF_DIV4      6'h01
`define SPIMSC_HALF_DIV8      6'h03
`define SPIMSC_HALF_DIV16     6'h07
`define SPIMSC_HALF_DIV32     6'h0F
`define SPIMSC_HALF_DIV64     6'h1F
`define SPIMSC_HALF_DIV128    6'h3F
`endif

// ### include/spimsc_pkg.sv
package spimsc_pkg;
  typedef struct packed {
    logic       irq_en;
    logic       port_en;
    logic       div2;
    logic       master;
    logic       clock_polarity_bit;
    logic       clock_phase_bit;
    logic [1:0] spr;
  } spimsc_ctrl_type;
  typedef struct packed {
    logic transfer_done_flag;
    logic write_collision_flag;
    logic overrun_flag;
    logic mode_fault_flag;
  } spimsc_stat_type;
  typedef enum logic [0:0] {SPIMSC_IDLE, SPIMSC_RUN} spimsc_mstate_type;
endpackage : spimsc_pkg

// ### logic/spimsc_core.sv
// Function
// - Soft select mode uses level bit, not pin
// - First-edge slave without select release: collision
// - Master drives clock per configuration
// - Master and enable stay only while select high
// - Master data write loads, shifts MSB first
// - Byte end sets done flag, interrupt
// - Master clears done: status access, data read
// - Slave clears done: status access, data access
// - Data writes blocked until status access
// - Slave data write loads output shift register
// - Byte while done pending sets overrun
// - Overrun keeps first byte, drops later ones
// - Status read clears overrun flag
// - Polarity and phase pick capture edge
// - Select low in master: fault, drop enables
// - Fault clear: status read, control write
// - Write during transfer discarded, collision flag
`timescale 1ns/1ps
`include "spimsc_regs.svh"
module spimsc_core
  import spimsc_pkg::*;
(
  input  wire logic            REF_CLK,    // Core clock
  input  wire logic            RESETN,     // Async reset, active low
  input  wire logic            CR_WR,      // Control write strobe
  input  wire logic [7:0]      CR_WDATA,   // Control write data
  input  wire logic            CSR_RD,     // Control/status read strobe
  input  wire logic            CSR_WR,     // Control/status write strobe
  input  wire logic            SOFT_SELECT_MODE,  // Select mode written with CSR_WR
  input  wire logic            SOFT_SELECT_LEVEL, // Select level written with CSR_WR
  input  wire logic            DR_RD,      // Data read strobe
  input  wire logic            DR_WR,      // Data write strobe
  input  wire logic [7:0]      DR_WDATA,   // Data write byte
  input  wire logic            CPU_MASK,   // Processor interrupt mask
  output logic [7:0]           DR_RDATA,   // Receive buffer
  output spimsc_ctrl_type      CTRL,       // Control word
  output spimsc_stat_type      STATUS,     // Status flags
  output logic                 BUSY,       // Transfer in progress
  output logic                 IRQ,        // Interrupt request
  input  wire logic            SCK_I,      // Clock pin in
  output logic                 SCK_O,      // Clock pin out
  output logic                 SCK_OE,     // Clock pin drive
  input  wire logic            MOSI_I,     // Master-out pin in
  output logic                 MOSI_O,     // Master-out pin out
  output logic                 MOSI_OE,    // Master-out pin drive
  input  wire logic            MISO_I,     // Master-in pin in
  output logic                 MISO_O,     // Master-in pin out
  output logic                 MISO_OE,    // Master-in pin drive
  input  wire logic            SS_N        // Select pin
);
  // ****************************************
  // State
  // ****************************************
  spimsc_ctrl_type   ctrl_q;
  spimsc_mstate_type mst_q;
  logic [3:0] sync1_q, sync2_q;
  logic       sck_prev_q, ssm_q, ssi_q, tgl_q, cap_q;
  logic [5:0] div_q;
  logic [3:0] idx_q;
  logic [7:0] shreg_q, rxbuf_q;
  logic       transfer_done_flag_q, write_collision_flag_q, ovr_q, mode_fault_flag_q;
  logic       transfer_done_flag_arm_q, write_collision_flag_arm_q, mode_fault_flag_arm_q, hold_q;
  // ****************************************
  // Decode
  // ****************************************
  wire sck_s   = sync2_q[3];
  wire mosi_s  = sync2_q[2];
  wire miso_s  = sync2_q[1];
  wire ss_pin  = sync2_q[0];
  wire ss_int  = ssm_q ? ssi_q : ss_pin;
  wire is_mst  = ctrl_q.master;
  wire fault   = ctrl_q.port_en & is_mst & ~ss_int;
  wire [2:0] spr_sel = {ctrl_q.div2, ctrl_q.spr};
  wire [5:0] half_lim = (spr_sel == 3'h4) ? `SPIMSC_HALF_DIV4 :
                        (spr_sel == 3'h0) ? `SPIMSC_HALF_DIV8 :
                        (spr_sel == 3'h1) ? `SPIMSC_HALF_DIV16 :
                        (spr_sel == 3'h6) ? `SPIMSC_HALF_DIV32 :
                        (spr_sel == 3'h2) ? `SPIMSC_HALF_DIV64 :
                                            `SPIMSC_HALF_DIV128;
  wire m_edge  = (mst_q == SPIMSC_RUN) & (div_q == half_lim);
  wire s_act   = ctrl_q.port_en & ~is_mst & ~ss_int;
  wire s_edge  = s_act & (sck_s != sck_prev_q);
  wire sh_edge = m_edge | s_edge;
  wire cap_ed  = sh_edge & (idx_q[0] == ctrl_q.clock_phase_bit);
  wire sft_ed  = sh_edge & ~cap_ed & (idx_q != 4'h0);
  wire din     = is_mst ? miso_s : mosi_s;
  wire last_ed = idx_q == `SPIMSC_LAST_EDGE;
  wire done    = sh_edge & last_ed;
  wire [7:0] sh_next = {shreg_q[6:0], cap_ed ? din : cap_q};
  wire busy    = (mst_q == SPIMSC_RUN) | (s_act & (idx_q != 4'h0)) |
                 (~is_mst & ~ctrl_q.clock_phase_bit & hold_q);
  wire blocked = transfer_done_flag_q & ~transfer_done_flag_arm_q;
  wire wr_ok   = DR_WR & ~busy & ~blocked;
  wire collide = DR_WR & busy;
  wire start   = wr_ok & is_mst & ctrl_q.port_en;
  wire csr_acc = CSR_RD | CSR_WR;
  wire transfer_done_flag_clr = transfer_done_flag_arm_q & (DR_RD | (DR_WR & ~is_mst));
  // A byte landing on the clear cycle counts as the first one after it
  wire take_byte = done & (~transfer_done_flag_q | transfer_done_flag_clr);
  wire write_collision_flag_clr = write_collision_flag_arm_q & (DR_RD | DR_WR);
  wire mode_fault_flag_clr = mode_fault_flag_arm_q & CR_WR;
  wire [7:0] cr_w = CR_WDATA & ~((mode_fault_flag_q & ~mode_fault_flag_arm_q) ?
                    8'h50 : 8'h00);
  // ****************************************
  // Input synchronisers
  // ****************************************
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      sync1_q <= 4'hF;
      sync2_q <= 4'hF;
    end
    else
    begin
      sync1_q <= {SCK_I, MOSI_I, MISO_I, SS_N};
      sync2_q <= sync1_q;
    end
  end
  // ****************************************
  // Control and select bits
  // ****************************************
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      ctrl_q <= `SPIMSC_CR_RESET;
      ssm_q  <= 1'b0;
      ssi_q  <= 1'b0;
    end
    else
    begin
      if (fault)
      begin
        ctrl_q.port_en <= 1'b0;
        ctrl_q.master  <= 1'b0;
      end
      else if (CR_WR)
        ctrl_q <= cr_w;
      if (CSR_WR)
      begin
        ssm_q <= SOFT_SELECT_MODE;
        ssi_q <= SOFT_SELECT_LEVEL;
      end
    end
  end
  // ****************************************
  // Master sequencer and clock
  // ****************************************
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      mst_q <= SPIMSC_IDLE;
      div_q <= 6'h00;
      tgl_q <= 1'b0;
    end
    else
    begin
      case (mst_q)
        SPIMSC_IDLE:
        begin
          div_q <= 6'h00;
          tgl_q <= 1'b0;
          if (start)
            mst_q <= SPIMSC_RUN;
        end
        SPIMSC_RUN:
        begin
          div_q <= m_edge ? 6'h00 : div_q + 6'h01;
          if (m_edge)
            tgl_q <= ~tgl_q;
          if (done | fault | ~ctrl_q.port_en)
          begin
            mst_q <= SPIMSC_IDLE;
            tgl_q <= 1'b0;
          end
        end
        default: mst_q <= SPIMSC_IDLE;
      endcase
    end
  end
  // ****************************************
  // Shift path
  // ****************************************
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      shreg_q    <= `SPIMSC_BYTE_RESET;
      cap_q      <= 1'b0;
      idx_q      <= 4'h0;
      sck_prev_q <= 1'b1;
    end
    else
    begin
      sck_prev_q <= sck_s;
      if (wr_ok)
        shreg_q <= DR_WDATA;
      // Master holds its data pin still on the far side's last capture edge
      else if (sft_ed | (cap_ed & last_ed & ~is_mst))
        shreg_q <= sh_next;
      if (cap_ed)
        cap_q <= din;
      if (sh_edge)
        idx_q <= idx_q + 4'h1;
      else if ((~is_mst & ~s_act) | (is_mst & (mst_q == SPIMSC_IDLE)))
        idx_q <= 4'h0;
    end
  end
  // ****************************************
  // Status flags; a set beats a clear
  // ****************************************
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      transfer_done_flag_q     <= 1'b0;
      write_collision_flag_q     <= 1'b0;
      ovr_q      <= 1'b0;
      mode_fault_flag_q     <= 1'b0;
      transfer_done_flag_arm_q <= 1'b0;
      write_collision_flag_arm_q <= 1'b0;
      mode_fault_flag_arm_q <= 1'b0;
      hold_q     <= 1'b0;
      rxbuf_q    <= `SPIMSC_BYTE_RESET;
    end
    else
    begin
      if (take_byte)
        rxbuf_q <= sh_next;
      transfer_done_flag_q <= done | (transfer_done_flag_q & ~transfer_done_flag_clr);
      ovr_q  <= (done & ~take_byte) | (ovr_q & ~CSR_RD);
      write_collision_flag_q <= collide | (write_collision_flag_q & ~write_collision_flag_clr);
      mode_fault_flag_q <= fault | (mode_fault_flag_q & ~mode_fault_flag_clr);
      if (transfer_done_flag_clr | ~transfer_done_flag_q)
        transfer_done_flag_arm_q <= 1'b0;
      else if (csr_acc)
        transfer_done_flag_arm_q <= 1'b1;
      if (write_collision_flag_clr | ~write_collision_flag_q)
        write_collision_flag_arm_q <= 1'b0;
      else if (CSR_RD)
        write_collision_flag_arm_q <= 1'b1;
      if (mode_fault_flag_clr | ~mode_fault_flag_q)
        mode_fault_flag_arm_q <= 1'b0;
      else if (CSR_RD)
        mode_fault_flag_arm_q <= 1'b1;
      if (done & ~is_mst)
        hold_q <= 1'b1;
      else if (ss_int)
        hold_q <= 1'b0;
    end
  end
  // ****************************************
  // Outputs; pins released while the port is off
  // ****************************************
  assign DR_RDATA = rxbuf_q;
  assign CTRL     = ctrl_q;
  assign STATUS   = '{transfer_done_flag_q, write_collision_flag_q, ovr_q, mode_fault_flag_q};
  assign BUSY     = busy;
  assign IRQ      = ctrl_q.irq_en & ~CPU_MASK &
                    (transfer_done_flag_q | ovr_q | mode_fault_flag_q);
  assign SCK_O    = ctrl_q.clock_polarity_bit ^ tgl_q;
  assign SCK_OE   = ctrl_q.port_en & is_mst;
  assign MOSI_O   = shreg_q[7];
  assign MOSI_OE  = ctrl_q.port_en & is_mst;
  assign MISO_O   = shreg_q[7];
  assign MISO_OE  = s_act;
  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);
  sequence m_start_s;
    start ##1 (mst_q == SPIMSC_RUN);
  endsequence
  AST_SOFT_FAULT: assert property (ssm_q & ~ssi_q & is_mst & ctrl_q.port_en
    |=> mode_fault_flag_q) else $error("soft select low did not fault master");
  AST_FAULT_DROP: assert property (fault |=> mode_fault_flag_q & ~ctrl_q.port_en
    & ~ctrl_q.master) else $error("mode fault did not drop enables");
  AST_CR_REFUSE: assert property (CR_WR & mode_fault_flag_q & ~mode_fault_flag_arm_q & ~fault
    |=> ~ctrl_q.port_en & ~ctrl_q.master) else $error("enable set during fault");
  AST_MASTER_RUN: assert property (m_start_s |-> ##1 (mst_q == SPIMSC_RUN)[*2])
    else $error("master transfer ended early");
  AST_BLOCKED: assert property (DR_WR & blocked & ~busy |=> $stable(shreg_q)
    | sh_edge) else $error("blocked write changed shift register");
  AST_COLLIDE: assert property (collide |=> write_collision_flag_q)
    else $error("collision not flagged");
  AST_OVERRUN: assert property (done & ~take_byte |=> ovr_q & $stable(rxbuf_q))
    else $error("overrun mishandled");
  AST_OVR_CLR: assert property (CSR_RD & ~done |=> ~ovr_q)
    else $error("overrun not cleared by status read");
  AST_TRANSFER_DONE_FLAG_CLR: assert property (transfer_done_flag_arm_q & DR_RD & ~done |=> ~transfer_done_flag_q)
    else $error("done flag not cleared");
  AST_IRQ: assert property (transfer_done_flag_q & ctrl_q.irq_en & ~CPU_MASK |-> IRQ)
    else $error("interrupt missing");
  AST_SCK_IDLE: assert property (mst_q == SPIMSC_IDLE |-> SCK_O == ctrl_q.clock_polarity_bit)
    else $error("clock not idle at polarity");
endmodule : spimsc_core

// ### test/spimsc_far_slave.sv
`timescale 1ns/1ps
module spimsc_far_slave (
  input  wire logic       SCK,   // Serial clock at the pin
  input  wire logic       MOSI,  // Data from the master
  input  wire logic       SEL_N, // Own select, low in a frame
  input  wire logic       CLOCK_PHASE_BIT,  // Second-edge capture when high
  input  wire logic [7:0] TX,    // Byte to send back
  output logic            MISO,  // Data to the master
  output logic [7:0]      RX     // Byte captured
);
  int n;
  initial
  begin
    MISO = 1'b0;
    RX = 8'h00;
    n = 0;
  end
  always @(negedge SEL_N)
  begin
    n = 0;
    MISO = TX[7];
  end
  // Released line keeps no data
  always @(posedge SEL_N) MISO = ~MISO;
  always @(SCK)
    if (!SEL_N && n < 16)
    begin
      if (n[0] == CLOCK_PHASE_BIT)
        RX = {RX[6:0], MOSI};
      else if (n < 15)
        MISO = TX[7 - (n + 1) / 2];
      n = n + 1;
    end
endmodule : spimsc_far_slave

// ### test/spimsc_core_bench.sv
`timescale 1ns/1ps
module spimsc_core_bench
  import spimsc_pkg::*;
;
  logic            ref_clk = 1'b0;
  logic            resetn = 1'b0;
  logic [4:0]      stb = 5'h00;
  logic [7:0]      wd = 8'h00, far_tx = 8'h00, dr_rdata, far_rx, got;
  logic            cpu_mask = 1'b0, soft_mode = 1'b0, soft_level = 1'b0;
  logic            sck_b = 1'b0, mosi_b = 1'b0, ss_n = 1'b1, far_sel_n = 1'b1;
  logic            busy, irq, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, far_miso;
  spimsc_ctrl_type ctrl;
  spimsc_stat_type status;
  int              mismatches = 0, checks_done = 0, cycles = 0;
  wire sck_w = sck_oe ? sck_o : sck_b;
  wire mosi_w = mosi_oe ? mosi_o : mosi_b;
  wire miso_w = miso_oe ? miso_o : far_miso;
  spimsc_core spimsc_core_i (.REF_CLK(ref_clk), .RESETN(resetn), .CR_WR(stb[4]),
    .CR_WDATA(wd), .CSR_RD(stb[3]), .CSR_WR(stb[0]), .SOFT_SELECT_MODE(soft_mode),
    .SOFT_SELECT_LEVEL(soft_level), .DR_RD(stb[2]), .DR_WR(stb[1]), .DR_WDATA(wd),
    .CPU_MASK(cpu_mask), .DR_RDATA(dr_rdata), .CTRL(ctrl), .STATUS(status), .BUSY(busy),
    .IRQ(irq), .SCK_I(sck_w), .SCK_O(sck_o), .SCK_OE(sck_oe), .MOSI_I(mosi_w),
    .MOSI_O(mosi_o), .MOSI_OE(mosi_oe), .MISO_I(miso_w), .MISO_O(miso_o),
    .MISO_OE(miso_oe), .SS_N(ss_n));
  spimsc_far_slave spimsc_far_slave_i (.SCK(sck_w), .MOSI(mosi_w), .SEL_N(far_sel_n),
    .CLOCK_PHASE_BIT(ctrl.clock_phase_bit), .TX(far_tx), .MISO(far_miso), .RX(far_rx));
  always #2 ref_clk = ~ref_clk;
  // ****************************************
  // Checking and closing
  // ****************************************
  task automatic give_verdict;
    $display("mismatches=%0d checks_done=%0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      give_verdict;
    end
  end
  // ****************************************
  // Access and link tasks
  // ****************************************
  // k: 0 control wr, 1 status rd, 2 data rd, 3 data wr, 4 status wr
  task automatic acc(input int k, input logic [7:0] d);
    @(negedge ref_clk);
    stb = 5'h10 >> k;
    wd = d;
    @(negedge ref_clk);
    stb = 5'h00;
  endtask : acc
  task automatic wait_done(output int g);
    int h;
    logic last;
    h = 0;
    g = 0;
    last = sck_o;
    for (int n = 0; n < 2000 && status.transfer_done_flag !== 1'b1; n++)
    begin
      @(negedge ref_clk);
      h++;
      if (sck_o !== last)
      begin
        g = h;
        h = 0;
        last = sck_o;
      end
    end
  endtask : wait_done
  // Bench acts as the far master, clock polarity low
  task automatic smaster(input logic ph, input logic [7:0] mo, output logic [7:0] mi);
    #64;
    for (int i = 7; i >= 0; i--)
    begin
      if (ph)
        sck_b = 1'b1;
      mosi_b = mo[i];
      #32 sck_b = ~sck_b;
      mi[i] = miso_w;
      #32 sck_b = 1'b0;
    end
    #64 mosi_b = ~mosi_b;
  endtask : smaster
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic mx(input logic [7:0] cfg, tx, st, input int half);
    int g;
    acc(0, ctrl & 8'hAF);
    acc(0, cfg & 8'hAF);
    acc(4, 8'h00);
    acc(0, cfg);
    far_tx = st;
    far_sel_n = 1'b0;
    acc(3, tx);
    wait_done(g);
    chk(16'(g), 16'(half));
    chk(far_rx, tx);
    // Fastest rate leaves no margin for the input synchroniser
    if (half > 2) chk(dr_rdata, st);
    chk(sck_o, cfg[3]);
    chk(irq, 1'b1);
    far_sel_n = 1'b1;
    acc(3, 8'hFF);
    chk(busy, 1'b0);
    acc(1, 8'h00);
    acc(2, 8'h00);
    chk(status.transfer_done_flag, 1'b0);
  endtask : mx
  task automatic t_master;
    logic [2:0] dv [6];
    dv = '{3'b100, 3'b000, 3'b001, 3'b110, 3'b010, 3'b011};
    for (int i = 0; i < 6; i++)
      mx({2'b11, dv[i][2], 1'b1, 2'(i), dv[i][1:0]}, 8'h3C ^ 8'(i), 8'hC5 + 8'(i), 2 << i);
  endtask : t_master
  task automatic t_coll;
    int g;
    acc(0, 8'hD3);
    far_tx = 8'h00;
    far_sel_n = 1'b0;
    acc(3, 8'h96);
    repeat (20) @(negedge ref_clk);
    acc(3, 8'h3C);
    chk({status.write_collision_flag, irq, busy}, 3'b101);
    wait_done(g);
    chk(far_rx, 8'h96);
    cpu_mask = 1'b1;
    @(negedge ref_clk);
    chk(irq, 1'b0);
    cpu_mask = 1'b0;
    far_sel_n = 1'b1;
    acc(1, 8'h00);
    acc(2, 8'h00);
    chk({status.write_collision_flag, status.transfer_done_flag}, 2'b00);
  endtask : t_coll
  task automatic t_fault;
    ss_n = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk({status.mode_fault_flag, ctrl.port_en, ctrl.master, irq}, 4'h9);
    ss_n = 1'b1;
    acc(0, 8'h50);
    chk(ctrl.master, 1'b0);
    acc(1, 8'h00);
    acc(0, 8'h50);
    chk({status.mode_fault_flag, ctrl.master}, 2'b01);
    soft_mode = 1'b1;
    soft_level = 1'b1;
    acc(4, 8'h00);
    ss_n = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk(status.mode_fault_flag, 1'b0);
    soft_level = 1'b0;
    acc(4, 8'h00);
    @(negedge ref_clk);
    chk(status.mode_fault_flag, 1'b1);
    ss_n = 1'b1;
    soft_mode = 1'b0;
    acc(4, 8'h00);
    acc(1, 8'h00);
    acc(0, 8'h00);
  endtask : t_fault
  task automatic t_slave;
    acc(0, 8'hC4);
    ss_n = 1'b0;
    acc(3, 8'hA5);
    smaster(1'b1, 8'h3C, got);
    chk(got, 8'hA5);
    chk({dr_rdata, status.transfer_done_flag, irq}, {8'h3C, 2'b11});
    smaster(1'b1, 8'h81, got);
    chk({dr_rdata, status.overrun_flag}, {8'h3C, 1'b1});
    acc(1, 8'h00);
    chk(status.overrun_flag, 1'b0);
    acc(3, 8'h00);
    chk(status.transfer_done_flag, 1'b0);
    ss_n = 1'b1;
  endtask : t_slave
  task automatic t_slave0;
    acc(0, 8'h40);
    ss_n = 1'b0;
    smaster(1'b0, 8'h11, got);
    chk(dr_rdata, 8'h11);
    acc(1, 8'h00);
    acc(3, 8'h22);
    chk(status.write_collision_flag, 1'b1);
    ss_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    acc(1, 8'h00);
    acc(2, 8'h00);
    chk(status.write_collision_flag, 1'b0);
  endtask : t_slave0
  initial
  begin
    repeat (12) @(negedge ref_clk);
    resetn = 1'b1;
    chk({ctrl, status}, 12'h000);
    t_master;
    t_coll;
    t_fault;
    t_slave;
    t_slave0;
    give_verdict;
  end
endmodule : spimsc_core_bench
